/* File: acr_params.svh */
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ----------------------------------------
// Software register indices
// ----------------------------------------
`define ACR_REG_CTRL      4'h0
`define ACR_REG_ADDR      4'h1
`define ACR_REG_WDATA     4'h2
`define ACR_REG_RDATA     4'h3
`define ACR_REG_BASE      4'h4
`define ACR_REG_PINS      4'h5
`define ACR_REG_OPTION    4'h6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ACR_CTRL_GO       0
`define ACR_CTRL_WRITE    1
`define ACR_CTRL_STORAGE  2
`define ACR_CTRL_RELATIVE 3
`define ACR_STAT_BUSY     4
`define ACR_STAT_DONE     5
`define ACR_STAT_REFUSED  6

// ----------------------------------------
// Card attribute map
// ----------------------------------------
`define ACR_STORAGE_BASE  11'h200
`define ACR_OFS_OPTION    11'h000
`define ACR_OFS_STATUS    11'h002
`define ACR_OPT_SOFT_RESET_BIT    7
`define ACR_OPT_LEVIRQ    6
// Keeps every option bit except the two reserved index bits
`define ACR_OPT_RSVD_MASK 8'hCF
`define ACR_BASE_RESET    11'h200

// ----------------------------------------
// Timing, ns
// ----------------------------------------
`define ACR_CLK_NS        100
`define ACR_SETUP_NS      100
`define ACR_STROBE_NS     300
`define ACR_RECOVER_NS    100

`endif

/* File: acr_pkg.sv */
package acr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER
    } acr_state_t;

endpackage : acr_pkg

/* File: acr_host.sv */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_host #(
    parameter int ADDR_W = 11
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // Software port
    input  wire logic [3:0]        sw_addr,
    input  wire logic [15:0]       sw_wdata,
    input  wire logic              sw_write,
    input  wire logic              sw_read,
    output logic      [15:0]       sw_rdata,
    // Card address and strobes
    output logic      [ADDR_W-1:0] card_addr,
    output logic                   attribute_select_n,
    output logic                   even_byte_enable_n,
    output logic                   odd_byte_enable_n,
    output logic                   output_strobe_n,
    output logic                   write_strobe_n,
    output logic                   card_reset,
    // Card data lines
    input  wire logic [15:0]       card_data_in,
    output logic      [15:0]       card_data_out,
    output logic                   card_data_oe_n,
    // Card status pins
    input  wire logic              status_change_pin_n,
    input  wire logic              interrupt_request_pin_n
);

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam int SETUP_RAW   = (`ACR_SETUP_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS;
    localparam int STROBE_RAW  = (`ACR_STROBE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS;
    localparam int RECOVER_RAW = (`ACR_RECOVER_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS;
    localparam logic [3:0] SETUP_CYC   = 4'(SETUP_RAW < 1 ? 1 : SETUP_RAW);
    localparam logic [3:0] STROBE_CYC  = 4'(STROBE_RAW < 1 ? 1 : STROBE_RAW);
    localparam logic [3:0] RECOVER_CYC = 4'(RECOVER_RAW < 1 ? 1 : RECOVER_RAW);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    acr_pkg::acr_state_t    state_reg;
    logic [3:0]             count_reg;
    logic                   write_mode_reg;
    logic                   storage_reg;
    logic                   relative_reg;
    logic [ADDR_W-1:0]      offset_reg;
    logic [ADDR_W-1:0]      base_reg;
    logic [7:0]             wdata_reg;
    logic [7:0]             rdata_reg;
    logic [7:0]             option_reg;
    logic                   done_reg;
    logic                   refused_reg;
    logic                   hard_reset_reg;
    logic [15:0]            data_meta_reg;
    logic [15:0]            data_sync_reg;
    logic [1:0]             pin_meta_reg;
    logic [1:0]             pin_sync_reg;
    logic [ADDR_W-1:0]      target_addr;
    logic [7:0]             out_byte;
    logic                   go_req;
    logic                   invalid;

    // ----------------------------------------
    // Address and validity
    // ----------------------------------------
    always_comb begin
        if (relative_reg) begin
            target_addr = (storage_reg ? `ACR_STORAGE_BASE : base_reg) + offset_reg;
        end else begin
            target_addr = offset_reg;
        end
    end

    // Odd or info-structure writes are never put on the pins
    always_comb begin
        invalid = target_addr[0];
        if (write_mode_reg && target_addr[10:9] == 2'b00) begin
            invalid = 1'b1;
        end
    end

    // Reserved index bits forced low on storage cards in relative mode
    always_comb begin
        out_byte = wdata_reg;
        if (storage_reg && relative_reg && offset_reg == `ACR_OFS_OPTION) begin
            out_byte = wdata_reg & `ACR_OPT_RSVD_MASK;
        end
    end

    assign go_req = sw_write && sw_addr == `ACR_REG_CTRL && sw_wdata[`ACR_CTRL_GO];

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            data_meta_reg <= 16'h0000;
            data_sync_reg <= 16'h0000;
            pin_meta_reg  <= 2'b11;
            pin_sync_reg  <= 2'b11;
        end else begin
            data_meta_reg <= card_data_in;
            data_sync_reg <= data_meta_reg;
            pin_meta_reg  <= {status_change_pin_n, interrupt_request_pin_n};
            pin_sync_reg  <= pin_meta_reg;
        end
    end

    // ----------------------------------------
    // Software-written settings
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            write_mode_reg <= 1'b0;
            storage_reg    <= 1'b1;
            relative_reg   <= 1'b1;
            offset_reg     <= '0;
            base_reg       <= `ACR_BASE_RESET;
            wdata_reg      <= 8'h00;
            hard_reset_reg <= 1'b0;
        end else if (sw_write) begin
            case (sw_addr)
                `ACR_REG_CTRL: begin
                    // Held while busy so a running cycle keeps its target
                    if (state_reg == acr_pkg::ST_IDLE) begin
                        write_mode_reg <= sw_wdata[`ACR_CTRL_WRITE];
                        storage_reg    <= sw_wdata[`ACR_CTRL_STORAGE];
                        relative_reg   <= sw_wdata[`ACR_CTRL_RELATIVE];
                    end
                end
                `ACR_REG_ADDR: begin
                    if (state_reg == acr_pkg::ST_IDLE) begin
                        offset_reg <= sw_wdata[ADDR_W-1:0];
                    end
                end
                `ACR_REG_WDATA: begin
                    if (state_reg == acr_pkg::ST_IDLE) begin
                        wdata_reg <= sw_wdata[7:0];
                    end
                end
                `ACR_REG_BASE: begin
                    base_reg <= sw_wdata[ADDR_W-1:0];
                end
                `ACR_REG_PINS: begin
                    hard_reset_reg <= sw_wdata[0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= acr_pkg::ST_IDLE;
            count_reg <= 4'h0;
        end else begin
            case (state_reg)
                acr_pkg::ST_IDLE: begin
                    if (go_req && !hard_reset_reg) begin
                        state_reg <= acr_pkg::ST_SETUP;
                        count_reg <= 4'h0;
                    end
                end
                acr_pkg::ST_SETUP: begin
                    if (invalid) begin
                        state_reg <= acr_pkg::ST_IDLE;
                    end else if (count_reg == SETUP_CYC - 4'h1) begin
                        state_reg <= acr_pkg::ST_STROBE;
                        count_reg <= 4'h0;
                    end else begin
                        count_reg <= count_reg + 4'h1;
                    end
                end
                acr_pkg::ST_STROBE: begin
                    if (count_reg == STROBE_CYC - 4'h1) begin
                        state_reg <= acr_pkg::ST_RECOVER;
                        count_reg <= 4'h0;
                    end else begin
                        count_reg <= count_reg + 4'h1;
                    end
                end
                acr_pkg::ST_RECOVER: begin
                    // Strobes and enable stay high here before any new cycle
                    if (count_reg == RECOVER_CYC - 4'h1) begin
                        state_reg <= acr_pkg::ST_IDLE;
                        count_reg <= 4'h0;
                    end else begin
                        count_reg <= count_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= acr_pkg::ST_IDLE;
                    count_reg <= 4'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Card pins
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            card_addr          <= '0;
            attribute_select_n <= 1'b1;
            even_byte_enable_n <= 1'b1;
            odd_byte_enable_n  <= 1'b1;
            output_strobe_n    <= 1'b1;
            write_strobe_n     <= 1'b1;
            card_data_out      <= 16'h0000;
            card_data_oe_n     <= 1'b1;
            card_reset         <= 1'b1;
        end else begin
            card_reset        <= hard_reset_reg;
            odd_byte_enable_n <= 1'b1;
            if (state_reg == acr_pkg::ST_SETUP && !invalid) begin
                card_addr          <= target_addr;
                attribute_select_n <= 1'b0;
                even_byte_enable_n <= 1'b0;
                card_data_out      <= {8'h00, out_byte};
                card_data_oe_n     <= !write_mode_reg;
                if (count_reg == SETUP_CYC - 4'h1) begin
                    output_strobe_n <= write_mode_reg;
                    write_strobe_n  <= !write_mode_reg;
                end
            end else if (state_reg == acr_pkg::ST_STROBE) begin
                if (count_reg == STROBE_CYC - 4'h1) begin
                    output_strobe_n    <= 1'b1;
                    write_strobe_n     <= 1'b1;
                    even_byte_enable_n <= 1'b1;
                end
            end else begin
                attribute_select_n <= 1'b1;
                even_byte_enable_n <= 1'b1;
                output_strobe_n    <= 1'b1;
                write_strobe_n     <= 1'b1;
                card_data_oe_n     <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Results and flags
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_reg   <= 8'h00;
            option_reg  <= 8'h00;
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            if (go_req) begin
                done_reg    <= 1'b0;
                refused_reg <= 1'b0;
            end
            if (state_reg == acr_pkg::ST_SETUP && invalid) begin
                refused_reg <= 1'b1;
                done_reg    <= 1'b1;
            end
            if (state_reg == acr_pkg::ST_STROBE && count_reg == STROBE_CYC - 4'h1) begin
                done_reg <= 1'b1;
                if (!write_mode_reg) begin
                    rdata_reg <= data_sync_reg[7:0];
                end
                if (relative_reg && offset_reg == `ACR_OFS_OPTION) begin
                    // Shadow of the option byte: soft reset and interrupt mode
                    option_reg <= write_mode_reg ? out_byte : data_sync_reg[7:0];
                end
            end
            if (hard_reset_reg) begin
                option_reg <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Software read port
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            sw_rdata <= 16'h0000;
        end else if (sw_read) begin
            case (sw_addr)
                `ACR_REG_CTRL: begin
                    sw_rdata <= {9'h000, refused_reg, done_reg,
                                 state_reg != acr_pkg::ST_IDLE, relative_reg,
                                 storage_reg, write_mode_reg, 1'b0};
                end
                `ACR_REG_ADDR:   sw_rdata <= 16'(offset_reg);
                `ACR_REG_WDATA:  sw_rdata <= {8'h00, wdata_reg};
                `ACR_REG_RDATA:  sw_rdata <= {8'h00, rdata_reg};
                `ACR_REG_BASE:   sw_rdata <= 16'(base_reg);
                `ACR_REG_PINS: begin
                    // Pin levels as seen, active high
                    sw_rdata <= {13'h0000, !pin_sync_reg[0], !pin_sync_reg[1],
                                 hard_reset_reg};
                end
                `ACR_REG_OPTION: sw_rdata <= {8'h00, option_reg};
                default:         sw_rdata <= 16'h0000;
            endcase
        end else begin
            sw_rdata <= 16'h0000;
        end
    end

endmodule : acr_host

/* File: acr_host_props.sv */
`timescale 1ns/1ps
module acr_host_props #(
    parameter int ADDR_W = 11
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // Card pins
    input wire logic [ADDR_W-1:0] card_addr,
    input wire logic              attribute_select_n,
    input wire logic              even_byte_enable_n,
    input wire logic              odd_byte_enable_n,
    input wire logic              output_strobe_n,
    input wire logic              write_strobe_n,
    input wire logic              card_reset,
    input wire logic [15:0]       card_data_out,
    input wire logic              card_data_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_read_frame: assert property (
        !output_strobe_n |-> write_strobe_n && card_data_oe_n && !attribute_select_n
            && !even_byte_enable_n) else $error("read strobe outside a read frame");
    chk_even_only: assert property (
        !output_strobe_n || !write_strobe_n |-> !card_addr[0] && odd_byte_enable_n)
        else $error("attribute access not even byte");
    chk_cis_write: assert property (
        !write_strobe_n |-> card_addr[10:9] != 2'b00) else $error("write into info area");
    chk_strobe_gap: assert property (
        $fell(output_strobe_n) || $fell(write_strobe_n) |-> $past(output_strobe_n)
            && $past(write_strobe_n)) else $error("strobes not released between cycles");
    chk_enable_release: assert property (
        $rose(output_strobe_n) || $rose(write_strobe_n) |-> even_byte_enable_n)
        else $error("enable held past strobe");
    chk_write_drive: assert property (
        !write_strobe_n |-> !card_data_oe_n && card_data_out[15:8] == 8'h00)
        else $error("write data not on low lane");
    chk_reset_idle: assert property (
        $fell(reset) |-> card_reset && output_strobe_n && write_strobe_n
            && attribute_select_n && card_data_oe_n) else $error("pins busy after reset");
    chk_hold_reset: assert property (
        card_reset |-> output_strobe_n && write_strobe_n) else $error("strobe during card reset");

    cover property ($fell(output_strobe_n));
    cover property ($fell(write_strobe_n));
    cover property ($rose(card_reset));
endmodule : acr_host_props

/* File: acr_card_model.sv */
`timescale 1ns/1ps
module acr_card_model #(
    parameter logic [10:0] CFG_BASE = 11'h200
) (
    // Clock for sampling strobes
    input  wire logic        clock,
    // Card pins
    input  wire logic [10:0] card_addr,
    input  wire logic        attribute_select_n,
    input  wire logic        even_byte_enable_n,
    input  wire logic        odd_byte_enable_n,
    input  wire logic        output_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        card_reset,
    input  wire logic [15:0] card_data_out,
    output logic      [15:0] card_data_in,
    output logic             status_change_pin_n,
    output logic             interrupt_request_pin_n
);
    logic [7:0]  option_reg;
    logic [7:0]  status_reg;
    logic        ready_changed;
    logic [15:0] float_reg = 16'h3C96;
    logic        hit;
    logic        cfg_hit;
    logic        cfg_wr;
    logic [7:0]  rd_byte;

    assign hit = !attribute_select_n && !even_byte_enable_n && odd_byte_enable_n
                 && !card_addr[0];
    assign cfg_hit = hit && (card_addr & 11'h7FD) == CFG_BASE;
    assign cfg_wr = cfg_hit && !write_strobe_n && output_strobe_n;
    assign rd_byte = !cfg_hit ? card_addr[8:1] ^ 8'h5A
                   : card_addr[1] ? {ready_changed, status_reg[6:2], ready_changed, 1'b0}
                   : option_reg;
    // Floating lines walk so a stale value never passes
    assign card_data_in = hit && !output_strobe_n && write_strobe_n
                        ? {float_reg[15:8], rd_byte} : float_reg;
    assign status_change_pin_n = !(ready_changed && status_reg[6]
                                   && option_reg[5:0] != 6'h00);
    // Power-state change doubles as the function's interrupt cause
    assign interrupt_request_pin_n = !(ready_changed && option_reg[0]
                                       && option_reg[2]);

    always @(posedge clock) begin
        float_reg <= {float_reg[14:0], ~float_reg[15]};
        if (card_reset) begin
            option_reg    <= 8'h00;
            status_reg    <= 8'h00;
            ready_changed <= 1'b0;
        end else begin
            if (cfg_wr && !card_addr[1])
                option_reg <= card_data_out[7] ? 8'h80 : card_data_out[7:0];
            if (option_reg[7]) begin
                status_reg    <= 8'h00;
                ready_changed <= 1'b0;
            end else if (cfg_wr && card_addr[1]) begin
                // Storage card: level-1 disable and audio stay zero
                status_reg <= card_data_out[7:0] & 8'h64;
                if (card_data_out[2] != status_reg[2])
                    ready_changed <= 1'b1;
            end
        end
    end
endmodule : acr_card_model

/* File: acr_host_tb.sv */
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_host_tb;
    localparam int          ADDR_W = 11;
    localparam logic [15:0] RD_REL = 16'h000D;
    localparam logic [15:0] WR_REL = 16'h000F;
    localparam logic [15:0] RD_ABS = 16'h0005;
    localparam logic [15:0] WR_ABS = 16'h0007;
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [3:0]        sw_addr = 4'h0;
    logic [15:0]       sw_wdata = 16'h0000;
    logic              sw_write = 1'b0;
    logic              sw_read = 1'b0;
    logic [15:0]       sw_rdata, card_data_in, card_data_out;
    logic [ADDR_W-1:0] card_addr;
    logic              attribute_select_n, even_byte_enable_n, odd_byte_enable_n;
    logic              output_strobe_n, write_strobe_n, card_reset, card_data_oe_n;
    logic              status_change_pin_n, interrupt_request_pin_n;
    int                err_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;

    always #50 clock = ~clock;

    acr_host #(.ADDR_W(ADDR_W)) dut (
        .clock(clock), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .card_addr(card_addr),
        .attribute_select_n(attribute_select_n), .even_byte_enable_n(even_byte_enable_n),
        .odd_byte_enable_n(odd_byte_enable_n), .output_strobe_n(output_strobe_n),
        .write_strobe_n(write_strobe_n), .card_reset(card_reset),
        .card_data_in(card_data_in), .card_data_out(card_data_out),
        .card_data_oe_n(card_data_oe_n), .status_change_pin_n(status_change_pin_n),
        .interrupt_request_pin_n(interrupt_request_pin_n));
    acr_card_model card (
        .clock(clock), .card_addr(card_addr), .attribute_select_n(attribute_select_n),
        .even_byte_enable_n(even_byte_enable_n), .odd_byte_enable_n(odd_byte_enable_n),
        .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
        .card_reset(card_reset), .card_data_out(card_data_out), .card_data_in(card_data_in),
        .status_change_pin_n(status_change_pin_n),
        .interrupt_request_pin_n(interrupt_request_pin_n));

    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clock);
        sw_write <= 1'b0;
        @(posedge clock);
    endtask : sw_wr

    task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clock);
        sw_read <= 1'b0;
        #1 d = sw_rdata;
        @(posedge clock);
    endtask : sw_rd

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        sw_rd(a, d);
        check(what, exp, d);
    endtask : rd_chk

    // One card cycle, waits for done with busy clear
    task automatic acc(input logic [15:0] ctl, input logic [10:0] a, input logic [7:0] d);
        logic [15:0] s;
        sw_wr(`ACR_REG_ADDR, {5'h00, a});
        sw_wr(`ACR_REG_WDATA, {8'h00, d});
        sw_wr(`ACR_REG_CTRL, ctl);
        s = 16'h0010;
        for (int i = 0; i < 30 && (s & 16'h0030) !== 16'h0020; i++)
            sw_rd(`ACR_REG_CTRL, s);
        if ((s & 16'h0030) !== 16'h0020)
            check("done flag", 16'h0020, s & 16'h0030);
    endtask : acc

    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd_chk(`ACR_REG_CTRL, 16'h000C, "ctrl after reset");
        acc(RD_REL, `ACR_OFS_OPTION, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0000, "option after reset");
        acc(RD_REL, `ACR_OFS_STATUS, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0000, "status after reset");
        for (int i = 0; i < 4; i++) begin
            acc(WR_REL, `ACR_OFS_OPTION, 8'(i));
            acc(RD_REL, `ACR_OFS_OPTION, 8'h00);
            rd_chk(`ACR_REG_RDATA, 16'(i), "index mode");
        end
        acc(WR_REL, `ACR_OFS_OPTION, 8'h7F);
        acc(RD_REL, `ACR_OFS_OPTION, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h004F, "option reserved index");
        rd_chk(`ACR_REG_OPTION, 16'h004F, "option shadow");
        acc(WR_REL, `ACR_OFS_STATUS, 8'hFC);
        acc(RD_REL, `ACR_OFS_STATUS, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h00E6, "status changed");
        rd_chk(`ACR_REG_PINS, 16'h0006, "change pin active");
        acc(WR_REL, `ACR_OFS_STATUS, 8'h24);
        acc(RD_REL, `ACR_OFS_STATUS, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h00A6, "status quiet");
        rd_chk(`ACR_REG_PINS, 16'h0004, "change pin idle");
        acc(WR_REL, `ACR_OFS_OPTION, 8'h81);
        acc(RD_REL, `ACR_OFS_OPTION, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0080, "soft reset held");
        acc(RD_REL, `ACR_OFS_STATUS, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0000, "status in soft reset");
        acc(WR_REL, `ACR_OFS_OPTION, 8'h00);
        acc(RD_ABS, 11'h200, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0000, "option unconfigured");
        acc(RD_REL, 11'h001, 8'h00);
        rd_chk(`ACR_REG_CTRL, 16'h006C, "odd read refused");
        acc(WR_ABS, 11'h004, 8'h55);
        rd_chk(`ACR_REG_CTRL, 16'h0066, "info write refused");
        acc(RD_ABS, 11'h004, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0058, "info byte");
        sw_wr(`ACR_REG_BASE, 16'h0300);
        rd_chk(`ACR_REG_BASE, 16'h0300, "base register");
        acc(16'h0009, 11'h004, 8'hA5);
        rd_chk(`ACR_REG_RDATA, 16'h00D8, "expansion base read");
        rd_chk(`ACR_REG_ADDR, 16'h0004, "address register");
        rd_chk(`ACR_REG_WDATA, 16'h00A5, "write data register");
        acc(WR_REL, `ACR_OFS_OPTION, 8'h41);
        sw_wr(`ACR_REG_PINS, 16'h0001);
        rd_chk(`ACR_REG_PINS, 16'h0001, "card reset pin");
        rd_chk(`ACR_REG_OPTION, 16'h0000, "shadow in card reset");
        sw_wr(`ACR_REG_PINS, 16'h0000);
        acc(RD_REL, `ACR_OFS_OPTION, 8'h00);
        rd_chk(`ACR_REG_RDATA, 16'h0000, "option after hard reset");
        rd_chk(4'h7, 16'h0000, "unmapped index");
        report_and_stop();
    end
endmodule : acr_host_tb

bind acr_host acr_host_props #(.ADDR_W(ADDR_W)) u_props (
    .clock(clock), .reset(reset), .card_addr(card_addr),
    .attribute_select_n(attribute_select_n), .even_byte_enable_n(even_byte_enable_n),
    .odd_byte_enable_n(odd_byte_enable_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .card_reset(card_reset),
    .card_data_out(card_data_out), .card_data_oe_n(card_data_oe_n));
